// ### design/bef_pkg.sv
// constants, types and timing for the back-emf event filter
package bef_pkg;
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned REF_HZ = 4000000;
  // window times in ns, as printed for the 4 MHz reference
  localparam int unsigned WIN_SHORT_STEP_NS = 5000;
  localparam int unsigned WIN_LONG_BASE_NS = 60000;
  localparam int unsigned WIN_LONG_STEP_NS = 20000;
  // windows count in cycles of the 4 MHz reference tick
  localparam int unsigned REF_DIV = CLK_HZ / REF_HZ;
  localparam int unsigned SHORT_STEP_TICKS = (WIN_SHORT_STEP_NS * (REF_HZ / 1000000)) / 1000;
  localparam int unsigned LONG_BASE_TICKS = (WIN_LONG_BASE_NS * (REF_HZ / 1000000)) / 1000;
  localparam int unsigned LONG_STEP_TICKS = (WIN_LONG_STEP_NS * (REF_HZ / 1000000)) / 1000;
  localparam logic [3:0] BLANK_TIME_RST = 4'hf;
  localparam logic [3:0] COUNT_LIMIT_RST = 4'h0;
  localparam int unsigned WIN_W = 10;
  localparam int unsigned DIV_W = 4;
  localparam int unsigned CNT_W = 5;
  localparam int unsigned RATE_W = 8;
  localparam logic [RATE_W-1:0] RATE_RST = 8'h00;
  // register map, byte addresses
  localparam logic [7:0] ADDR_DEMAG_FILTER = 8'h00;
  localparam logic [7:0] ADDR_ZERO_FILTER = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_RATE = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  // control bit positions
  localparam int unsigned CTL_SENSOR = 0;
  localparam int unsigned CTL_SAME_EDGE = 1;
  localparam int unsigned CTL_POLARITY = 2;
  // irq status bit positions
  localparam int unsigned IRQ_DEMAG = 0;
  localparam int unsigned IRQ_ZERO = 1;

  typedef enum logic [1:0] {
    BEF_WAIT_C,
    BEF_DEMAG,
    BEF_ZERO
  } bef_phase_e;

  typedef struct packed {
    logic [3:0] blank_time;
    logic [3:0] count_limit;
  } bef_filter_s;

  typedef struct packed {
    logic [DIV_W-1:0] ref_div;
    logic [RATE_W-1:0] rate_cnt;
    bef_filter_s demag_cfg;
    bef_filter_s zero_cfg;
    logic [2:0] ctl;
    logic [RATE_W-1:0] rate;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic [31:0] rdata;
    bef_phase_e phase;
    logic [WIN_W-1:0] win_cnt;
    logic [CNT_W-1:0] run_cnt;
    logic demag_flag;
    logic zero_flag;
    logic demag_evt;
    logic zero_evt;
    logic cmp_s1;
    logic cmp_s2;
    logic cmp_prev;
  } bef_state_s;
endpackage : bef_pkg

// ### design/bef_event_filter.sv
// back-emf demagnetization and zero-crossing event qualification
//
// The address map and strobed register access were decided locally.
module bef_event_filter (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmp_in,
  input wire logic comm_hw,
  input wire logic comm_sw,
  input wire logic demag_sim,
  input wire logic zero_sim,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  output logic demag_event,
  output logic zero_event,
  output logic demag_flag,
  output logic zero_flag,
  output logic irq
);

  bef_pkg::bef_state_s st;
  bef_pkg::bef_state_s next_st;

  // window length in reference ticks for a 4-bit code
  function automatic logic [bef_pkg::WIN_W-1:0] win_ticks(input logic [3:0] code);
    int unsigned t;
    if (!code[3]) begin
      t = (int'(code) + 1) * bef_pkg::SHORT_STEP_TICKS;
    end else begin
      t = bef_pkg::LONG_BASE_TICKS + int'(code[2:0]) * bef_pkg::LONG_STEP_TICKS;
    end
    return t[bef_pkg::WIN_W-1:0];
  endfunction : win_ticks

  logic comm;
  logic ref_tick;
  logic samp_tick;
  logic sensor;
  logic lvl_demag;
  logic lvl_zero;
  logic edge_demag;
  logic edge_zero;
  logic [3:0] limit;
  logic match;
  logic win_open;

  always_comb begin
    comm = comm_hw | comm_sw;
    ref_tick = (st.ref_div == 4'(bef_pkg::REF_DIV - 1));
    samp_tick = ref_tick && (st.rate_cnt == st.rate);
    sensor = st.ctl[bef_pkg::CTL_SENSOR];
    // polarity picks demag level; zero-cross uses opposite level unless same-edge set
    lvl_demag = st.ctl[bef_pkg::CTL_POLARITY];
    lvl_zero = st.ctl[bef_pkg::CTL_SAME_EDGE] ? lvl_demag : ~lvl_demag;
    edge_demag = (st.cmp_s2 == lvl_demag) && (st.cmp_prev != lvl_demag);
    edge_zero = (st.cmp_s2 == lvl_zero) && (st.cmp_prev != lvl_zero);
    win_open = (st.win_cnt == '0) || sensor;
    limit = (st.phase == bef_pkg::BEF_DEMAG) ? st.demag_cfg.count_limit : st.zero_cfg.count_limit;
    if (st.phase == bef_pkg::BEF_DEMAG && sensor) begin
      limit = 4'h0;
    end
    // first sample of a run must be the edge, later ones just the level
    if (st.phase == bef_pkg::BEF_DEMAG) begin
      match = (st.run_cnt == '0) ? edge_demag : (st.cmp_s2 == lvl_demag);
    end else begin
      match = (st.run_cnt == '0) ? edge_zero : (st.cmp_s2 == lvl_zero);
    end
  end

  always_comb begin
    next_st = st;
    next_st.demag_evt = 1'b0;
    next_st.zero_evt = 1'b0;
    // comparator from the analog side: two-stage synchroniser
    next_st.cmp_s1 = cmp_in;
    next_st.cmp_s2 = st.cmp_s1;
    next_st.ref_div = ref_tick ? '0 : st.ref_div + 4'h1;
    if (ref_tick) begin
      next_st.rate_cnt = (st.rate_cnt == st.rate) ? '0 : st.rate_cnt + 8'h01;
    end
    if (samp_tick) begin
      next_st.cmp_prev = st.cmp_s2;
    end
    if (ref_tick && st.win_cnt != '0) begin
      next_st.win_cnt = st.win_cnt - 10'(1);
    end

    // event sequencing
    if (comm) begin
      next_st.phase = bef_pkg::BEF_DEMAG;
      next_st.win_cnt = win_ticks(st.demag_cfg.blank_time);
      next_st.run_cnt = '0;
      next_st.demag_flag = 1'b0;
      next_st.zero_flag = 1'b0;
    end else begin
      case (st.phase)
        bef_pkg::BEF_DEMAG: begin
          if (demag_sim) begin
            next_st.demag_evt = 1'b1;
          end else if (samp_tick && win_open) begin
            if (!match) begin
              next_st.run_cnt = '0;
            end else if (st.run_cnt == 5'(limit)) begin
              next_st.demag_evt = 1'b1;
            end else begin
              next_st.run_cnt = st.run_cnt + 5'h01;
            end
          end
          if (next_st.demag_evt) begin
            next_st.demag_flag = 1'b1;
            next_st.phase = bef_pkg::BEF_ZERO;
            next_st.win_cnt = win_ticks(st.zero_cfg.blank_time);
            next_st.run_cnt = '0;
          end
        end
        bef_pkg::BEF_ZERO: begin
          if (zero_sim) begin
            next_st.zero_evt = 1'b1;
          end else if (samp_tick && win_open) begin
            if (!match) begin
              next_st.run_cnt = '0;
            end else if (st.run_cnt == 5'(limit)) begin
              next_st.zero_evt = 1'b1;
            end else begin
              next_st.run_cnt = st.run_cnt + 5'h01;
            end
          end
          if (next_st.zero_evt) begin
            next_st.zero_flag = 1'b1;
            next_st.phase = bef_pkg::BEF_WAIT_C;
            next_st.run_cnt = '0;
          end
        end
        bef_pkg::BEF_WAIT_C: begin
          // waits for next commutation
        end
        default: begin
          next_st.phase = bef_pkg::BEF_WAIT_C;
        end
      endcase
    end

    // register port
    next_st.rdata = '0;
    if (wr) begin
      case (addr)
        bef_pkg::ADDR_DEMAG_FILTER: next_st.demag_cfg = wdata[7:0];
        bef_pkg::ADDR_ZERO_FILTER: next_st.zero_cfg = wdata[7:0];
        bef_pkg::ADDR_CONTROL: next_st.ctl = wdata[2:0];
        bef_pkg::ADDR_RATE: next_st.rate = wdata[bef_pkg::RATE_W-1:0];
        bef_pkg::ADDR_IRQ_MASK: next_st.irq_mask = wdata[1:0];
        default: begin
        end
      endcase
    end
    if (rd) begin
      case (addr)
        bef_pkg::ADDR_DEMAG_FILTER: next_st.rdata = {24'h000000, st.demag_cfg};
        bef_pkg::ADDR_ZERO_FILTER: next_st.rdata = {24'h000000, st.zero_cfg};
        bef_pkg::ADDR_CONTROL: next_st.rdata = {27'h0000000, st.demag_flag, st.zero_flag, st.ctl};
        bef_pkg::ADDR_RATE: next_st.rdata = {24'h000000, st.rate};
        bef_pkg::ADDR_IRQ_STATUS: begin
          next_st.rdata = {30'h00000000, st.irq_status};
          next_st.irq_status = 2'b00; // read clears
        end
        bef_pkg::ADDR_IRQ_MASK: next_st.rdata = {30'h00000000, st.irq_mask};
        default: next_st.rdata = '0;
      endcase
    end
    // set wins over the read clear
    if (st.demag_evt) begin
      next_st.irq_status[bef_pkg::IRQ_DEMAG] = 1'b1;
    end
    if (st.zero_evt) begin
      next_st.irq_status[bef_pkg::IRQ_ZERO] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      st.demag_cfg <= '{bef_pkg::BLANK_TIME_RST, bef_pkg::COUNT_LIMIT_RST};
      st.zero_cfg <= '{bef_pkg::BLANK_TIME_RST, bef_pkg::COUNT_LIMIT_RST};
      st.rate <= bef_pkg::RATE_RST;
      st.phase <= bef_pkg::BEF_WAIT_C;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign demag_event = st.demag_evt;
  assign zero_event = st.zero_evt;
  assign demag_flag = st.demag_flag;
  assign zero_flag = st.zero_flag;
  assign irq = |(st.irq_status & st.irq_mask);

endmodule : bef_event_filter

// ### bench/bef_phase_model.sv
// comparator output seen through the floating motor phase
module bef_phase_model (
  input wire logic lvl,
  output logic cmp_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cmp_in = 1'b1;
  // small lag, so edges never line up with the sampler clock
  always @(lvl) cmp_in <= #3 lvl;
endmodule : bef_phase_model

// ### bench/bef_event_filter_chk.sv
// port assertions for the back-emf event filter
module bef_chk (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic comm_hw,
  input wire logic comm_sw,
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic demag_event,
  input wire logic zero_event,
  input wire logic demag_flag,
  input wire logic zero_flag,
  input wire logic irq
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  a_demag_one_pulse: assert property (demag_event |=> !demag_event) else $error("demag pulse long");
  a_zero_one_pulse: assert property (zero_event |=> !zero_event) else $error("zero pulse long");
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h0) else $error("rdata not idle");
  a_comm_clears: assert property (comm_hw || comm_sw |=> !demag_flag && !zero_flag) else $error("flags kept");
  a_demag_sets_flag: assert property (demag_event |-> ##[0:1] demag_flag) else $error("no demag flag");
  a_zero_after_demag: assert property (zero_event |-> demag_flag) else $error("zero out of order");
  a_irq_cause: assert property ($rose(irq) |-> demag_event || zero_event || $past(wr)
    || $past(demag_event || zero_event)) else $error("irq without cause");
  a_read_clears: assert property (rd && addr == bef_pkg::ADDR_IRQ_STATUS |=> !irq || $past(demag_event || zero_event))
    else $error("status not cleared");
endmodule : bef_chk

// ### bench/test_bef_event_filter.sv
// self-checking bench for the back-emf event filter
module test_bef_event_filter;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk, nrst, lvl, cmp_in, wr, rd;
  logic [3:0] ev;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic demag_event, zero_event, demag_flag, zero_flag, irq;
  int fails, n_compared;
  // addr, write, readback; last row is unmapped
  logic [71:0] rows [5] = '{{8'h00, 32'h5a, 32'h5a}, {8'h04, 32'hffffffa5, 32'ha5},
    {8'h0c, 32'h3, 32'h3}, {8'h14, 32'h3, 32'h3}, {8'h18, 32'hff, 32'h0}};
  bef_phase_model phase (.lvl(lvl), .cmp_in(cmp_in));
  bef_event_filter uut (.ref_clk(ref_clk), .nrst(nrst), .cmp_in(cmp_in), .comm_hw(ev[0]),
    .comm_sw(ev[1]), .demag_sim(ev[2]), .zero_sim(ev[3]), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .demag_event(demag_event), .zero_event(zero_event),
    .demag_flag(demag_flag), .zero_flag(zero_flag), .irq(irq));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task conclude;
    if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task wreg(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1 chk("rdata", exp, rdata);
  endtask : rreg
  task pulse(input logic [3:0] p);
    @(posedge ref_clk);
    ev <= p;
    @(posedge ref_clk);
    ev <= 4'h0;
  endtask : pulse
  // lo == hi: no event allowed; else event due in [lo, hi)
  task wait_ev(input bit z, input int lo, input int hi);
    int n;
    for (n = 0; n < hi; n++) begin
      @(posedge ref_clk);
      #1;
      if ((z ? zero_event : demag_event) === 1'b1) break;
    end
    chk("event time", 32'h1, 32'(lo == hi ? n == hi : n >= lo && n < hi));
    if (lo != hi && n == hi) conclude();
  endtask : wait_ev
  initial begin
    nrst = 1'b0;
    lvl = 1'b1;
    ev = 4'h0;
    addr = 8'h00;
    wdata = 32'h0;
    wr = 1'b0;
    rd = 1'b0;
    fails = 0;
    n_compared = 0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    foreach (rows[i]) begin
      wreg(rows[i][71:64], rows[i][63:32]);
      rreg(rows[i][71:64], rows[i][31:0]);
    end
    // reset again in mid-run, then check reset values
    @(posedge ref_clk) nrst <= 1'b0;
    repeat (20) @(posedge ref_clk);
    nrst <= 1'b1;
    rreg(8'h00, 32'hf0);
    rreg(8'h04, 32'hf0);
    rreg(8'h14, 32'h0);
    wreg(8'h00, 32'h02);
    wreg(8'h14, 32'h3);
    // 5us window is 200 clocks; a glitch inside it must be hidden
    pulse(4'h1);
    @(posedge ref_clk) lvl <= 1'b0;
    wait_ev(1'b0, 60, 60);
    @(posedge ref_clk) lvl <= 1'b1;
    wait_ev(1'b0, 180, 180);
    @(posedge ref_clk) lvl <= 1'b0;
    wait_ev(1'b0, 20, 80);
    rreg(8'h08, 32'h10);
    // zero window left at 200us, 8000 clocks
    @(posedge ref_clk) lvl <= 1'b1;
    wait_ev(1'b1, 100, 100);
    @(posedge ref_clk) lvl <= 1'b0;
    wait_ev(1'b1, 7950, 7950);
    @(posedge ref_clk) lvl <= 1'b1;
    wait_ev(1'b1, 0, 40);
    chk("irq", 32'h1, 32'(irq));
    rreg(8'h10, 32'h3);
    chk("irq", 32'h0, 32'(irq));
    // software commutation, then simulated events
    wreg(8'h04, 32'h0);
    pulse(4'h2);
    rreg(8'h08, 32'h0);
    repeat (250) @(posedge ref_clk);
    pulse(4'h4);
    #1 chk("demag_event", 32'h1, 32'(demag_event));
    repeat (250) @(posedge ref_clk);
    pulse(4'h8);
    #1 chk("zero_event", 32'h1, 32'(zero_event));
    // sensor mode: no blanking after commutation
    wreg(8'h08, 32'h1);
    pulse(4'h1);
    @(posedge ref_clk) lvl <= 1'b0;
    wait_ev(1'b0, 0, 60);
    // other polarity, same edge for both events, sampling every 20 clocks
    wreg(8'h0c, 32'h1);
    wreg(8'h08, 32'h6);
    wreg(8'h00, 32'h01);
    pulse(4'h1);
    repeat (250) @(posedge ref_clk);
    lvl <= 1'b1;
    wait_ev(1'b0, 20, 45);
    @(posedge ref_clk) lvl <= 1'b0;
    repeat (250) @(posedge ref_clk);
    lvl <= 1'b1;
    wait_ev(1'b1, 0, 25);
    rreg(8'h08, 32'h1e);
    conclude();
  end
endmodule : test_bef_event_filter
bind bef_event_filter bef_chk chk (.ref_clk(ref_clk), .nrst(nrst), .comm_hw(comm_hw), .comm_sw(comm_sw),
  .addr(addr), .wr(wr), .rd(rd), .rdata(rdata), .demag_event(demag_event), .zero_event(zero_event),
  .demag_flag(demag_flag), .zero_flag(zero_flag), .irq(irq));
